// File: common/dsdpc_pkg.sv
// Shared constants and types for the deep sleep and debug power controller
package dsdpc_pkg;

  // Bus widths
  localparam int unsigned AHB_AW = 32;  // Address width
  localparam int unsigned AHB_DW = 32;  // Data width

  // Register byte addresses
  localparam logic [31:0] ADDR_SLEEP_CTRL = 32'h4000_4030;  // Deep sleep options
  localparam logic [31:0] ADDR_SLEEP_STAT = 32'h4000_4034;  // State and wake causes
  localparam logic [31:0] ADDR_CLK_GATE   = 32'h4000_4038;  // peripheral_clock_gate
  localparam logic [31:0] ADDR_SC1_BASE   = 32'h4000_c000;  // Serial controller one regs

  // Serial controller one register bank
  localparam int unsigned SC1_WORDS = 8;  // Words in the bank
  localparam int unsigned SC1_AW    = 3;  // Word index width

  // peripheral_clock_gate fields and reset
  localparam int unsigned GATE_SC1_BIT  = 1;  // serial_ctrl1_clock_off
  localparam int unsigned GATE_RSVD_BIT = 5;  // reserved_preserve_bit
  localparam logic [31:0] GATE_RESET    = 32'h0000_0000;

  // Sleep control fields and reset
  localparam int unsigned CTRL_DS2_BIT  = 0;  // Select deep sleep 2
  localparam int unsigned CTRL_XTAL_BIT = 1;  // Crystal times the sleep timer
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  // Sleep status fields
  localparam int unsigned STAT_STATE_LSB = 0;  // State code, three bits
  localparam int unsigned STAT_RCOSC_BIT = 3;  // RC oscillator running
  localparam int unsigned STAT_DBG_BIT   = 4;  // Debug power-up request seen
  localparam int unsigned STAT_SYS_BIT   = 5;  // System power-up request seen
  localparam int unsigned STAT_PWR_BIT   = 6;  // Core domain powered
  localparam int unsigned STAT_WAKE_LSB  = 8;  // Sticky wake causes, three bits

  // Wake cause bit positions within the sticky field
  localparam int unsigned WAKE_EXT   = 0;
  localparam int unsigned WAKE_TIMER = 1;
  localparam int unsigned WAKE_DEBUG = 2;

  // Core power-up settle time, least value
  localparam int unsigned POWERUP_TIME_NS = 2000;
  localparam int unsigned CLK_PERIOD_PS   = 8000;
  localparam int unsigned POWERUP_CYCLES  =
    (POWERUP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned PWR_CNT_W       = $clog2(POWERUP_CYCLES + 1);

  // Power controller states
  typedef enum logic [2:0] {
    DSDPC_RUN  = 3'h0,  // Awake
    DSDPC_PRE  = 3'h1,  // Pre-deep-sleep hold
    DSDPC_DEEP = 3'h2,  // True deep sleep, core off
    DSDPC_EMUL = 3'h3,  // Emulated deep sleep 0
    DSDPC_WAKE = 3'h4   // Core powering up
  } dsdpc_state_t;

endpackage

// File: common/dsdpc_sc1_if.sv
// Link between the controller and the serial controller one register bank
`timescale 1ns/1ps
interface dsdpc_sc1_if #(
  parameter int unsigned AW = 3
);
  logic          wr_en;   // Write strobe
  logic          rd_en;   // Read strobe
  logic [AW-1:0] addr;    // Word index
  logic [31:0]   wdata;   // Write data
  logic [31:0]   rdata;   // Registered read data
  logic          clk_on;  // Bank clock running

  modport ctrl (output wr_en, output rd_en, output addr, output wdata, output clk_on,
                input rdata);
  modport bank (input wr_en, input rd_en, input addr, input wdata, input clk_on,
                output rdata);
endinterface

// File: hdl/dsdpc_sc1_regs.sv
// Serial controller one register bank that freezes while its clock is gated
`timescale 1ns/1ps
module dsdpc_sc1_regs #(
  parameter int unsigned WORDS = 8,
  parameter int unsigned AW    = 3
) (
  input  logic      sys_clk,
  input  logic      rst_n,
  dsdpc_sc1_if.bank port
);
  import dsdpc_pkg::*;

  // Whole state of the bank
  typedef struct packed {
    logic [WORDS-1:0][31:0] mem;    // Register contents
    logic [31:0]            rdata;  // Read data register
  } dsdpc_bank_t;

  dsdpc_bank_t r;       // Current state
  dsdpc_bank_t next_r;  // Next state

  // Index must cover the whole bank
  if (WORDS > (1 << AW)) begin : g_chk
    $error("dsdpc_sc1_regs: WORDS does not fit AW");
  end

  // Writes are dropped while gated, so reads show the frozen values
  always_comb begin
    next_r = r;
    if (port.wr_en && port.clk_on && (32'(port.addr) < WORDS)) begin
      next_r.mem[port.addr] = port.wdata;
    end
    if (port.rd_en) begin
      next_r.rdata = (32'(port.addr) < WORDS) ? r.mem[port.addr] : 32'h0000_0000;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign port.rdata = r.rdata;
endmodule

// File: hdl/dsdpc_top.sv
// Deep sleep and debug power controller with its AHB-Lite register slave
`timescale 1ns/1ps

module dsdpc_top (
  input  logic                          sys_clk,
  input  logic                          rst_n,
  // AHB-Lite slave
  input  logic                          hsel,
  input  logic [dsdpc_pkg::AHB_AW-1:0]  haddr,
  input  logic [1:0]                    htrans,
  input  logic                          hwrite,
  input  logic [2:0]                    hsize,
  input  logic [dsdpc_pkg::AHB_DW-1:0]  hwdata,
  input  logic                          hready,
  output logic [dsdpc_pkg::AHB_DW-1:0]  hrdata,
  output logic                          hreadyout,
  output logic                          hresp,
  // Debug port side
  input  logic                          debug_powerup_request,
  input  logic                          system_powerup_request,
  input  logic                          dp_clk,
  input  logic                          dp_access_req,
  output logic                          dp_stall,
  // Core and wake side
  input  logic                          cpu_deep_sleep_req,
  input  logic                          ext_wake,
  input  logic                          timer_wake_event,
  output logic                          core_power_on,
  output logic                          core_reset_n,
  output logic                          periph_reset_n,
  output logic                          low_freq_rc_osc_on,
  output logic                          timer_wake_armed,
  output logic                          sc1_clk_on
);
  import dsdpc_pkg::*;

  // Settle count must be at least one cycle
  if (POWERUP_CYCLES < 1) begin : g_chk
    $error("dsdpc_top: power-up count below one cycle");
  end

  // Whole state of the controller
  typedef struct packed {
    logic [1:0]           dbg_sync;    // Debug request synchroniser
    logic [1:0]           sys_sync;    // System request synchroniser
    logic [1:0]           ext_sync;    // External wake synchroniser
    logic [1:0]           acc_sync;    // Access request synchroniser
    logic [2:0]           clk_sync;    // Link clock sampler plus edge history
    dsdpc_state_t         state;       // Power state
    logic                 ds2_latched; // Variant taken at entry
    logic [PWR_CNT_W-1:0] pwr_cnt;     // Power-up settle counter
    logic                 acc_pend;    // Debugger access waiting
    logic                 sc1_off;     // serial_ctrl1_clock_off
    logic                 rsvd;        // reserved_preserve_bit
    logic                 ds2_sel;     // Software picks deep sleep 2
    logic                 xtal_sel;    // Crystal drives sleep timer
    logic [2:0]           wake_cause;  // Sticky wake causes
    logic                 dp_pend;     // Bus data phase pending
    logic                 dp_write;    // Pending phase is a write
    logic [31:0]          dp_addr;     // Pending address
    logic                 rd_wait;     // Read wait state done
    logic                 rd_mem;      // Read comes from the bank
    logic [31:0]          rd_word;     // Registered read word
  } dsdpc_ctl_t;

  dsdpc_ctl_t r;       // Current state
  dsdpc_ctl_t next_r;  // Next state

  dsdpc_sc1_if #(.AW(SC1_AW)) sc1_bus ();  // Link to the register bank

  // Synchronised views, read from the second stage, clk_rise also the third; ready decodes the state, timer_ok gates the raw timer event
  logic dbg_req;   // Debug power-up request
  logic sys_req;   // System power-up request
  logic ext_req;   // Non-timer wake
  logic clk_rise;  // Link clock rising edge
  logic ready;     // Core powered and out of reset
  logic timer_ok;  // Timer wake allowed now

  assign dbg_req  = r.dbg_sync[1];
  assign sys_req  = r.sys_sync[1];
  assign ext_req  = r.ext_sync[1];
  assign clk_rise = r.clk_sync[1] & ~r.clk_sync[2];

  // Address match helper
  function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
    hit = (a[31:2] == target[31:2]);
  endfunction

  // Bank window match helper
  function automatic logic sc1_hit(input logic [31:0] a);
    sc1_hit = (a[31:SC1_AW+2] == ADDR_SC1_BASE[31:SC1_AW+2]);
  endfunction

  // Read data of the own registers
  function automatic logic [31:0] own_word(input dsdpc_ctl_t s, input logic [31:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (hit(a, ADDR_CLK_GATE)) begin
      // Only bits 1 and 5 exist
      w[GATE_SC1_BIT]  = s.sc1_off;
      w[GATE_RSVD_BIT] = s.rsvd;
    end else if (hit(a, ADDR_SLEEP_CTRL)) begin
      w[CTRL_DS2_BIT]  = s.ds2_sel;
      w[CTRL_XTAL_BIT] = s.xtal_sel;
    end else if (hit(a, ADDR_SLEEP_STAT)) begin
      w[STAT_STATE_LSB +: 3] = s.state;
      w[STAT_RCOSC_BIT]      = ~((s.state == DSDPC_DEEP) & s.ds2_latched);
      w[STAT_DBG_BIT]        = s.dbg_sync[1];
      w[STAT_SYS_BIT]        = s.sys_sync[1];
      w[STAT_PWR_BIT]        = (s.state != DSDPC_DEEP);
      w[STAT_WAKE_LSB +: 3]  = s.wake_cause;
    end
    own_word = w;
  endfunction

  // Core ready for debug traffic when powered and not in reset
  assign ready = (r.state == DSDPC_RUN) | (r.state == DSDPC_PRE) | (r.state == DSDPC_EMUL);

  // Timer wakes need the RC oscillator or the crystal
  assign timer_ok = timer_wake_event & (~r.ds2_latched | r.xtal_sel);

  // Read needs one wait state so reads follow back-to-back writes correctly
  assign hreadyout = ~(r.dp_pend & ~r.dp_write & ~r.rd_wait);
  assign hresp     = 1'b0;
  assign hrdata    = r.rd_mem ? sc1_bus.rdata : r.rd_word;

  // Bank strobes come from the pending data phase
  assign sc1_bus.wr_en  = r.dp_pend & r.dp_write & sc1_hit(r.dp_addr);
  assign sc1_bus.rd_en  = r.dp_pend & ~r.dp_write & ~r.rd_wait & sc1_hit(r.dp_addr);
  assign sc1_bus.addr   = r.dp_addr[SC1_AW+1:2];
  assign sc1_bus.wdata  = hwdata;
  assign sc1_bus.clk_on = ~r.sc1_off;

  // Next-state logic
  always_comb begin
    next_r = r;

    // Two-stage synchronisers; the link clock keeps one extra stage for edges
    next_r.dbg_sync = {r.dbg_sync[0], debug_powerup_request};
    next_r.sys_sync = {r.sys_sync[0], system_powerup_request};
    next_r.ext_sync = {r.ext_sync[0], ext_wake};
    next_r.acc_sync = {r.acc_sync[0], dp_access_req};
    next_r.clk_sync = {r.clk_sync[1:0], dp_clk};

    // Debugger access is seen on link clock edges; held off until ready
    if (clk_rise && r.acc_sync[1] && !ready) begin
      next_r.acc_pend = 1'b1;
    end else if (ready) begin
      next_r.acc_pend = 1'b0;
    end

    // Bus data phase
    if (r.dp_pend) begin
      if (r.dp_write) begin
        // Zero wait write
        if (hit(r.dp_addr, ADDR_CLK_GATE)) begin
          // Software must write bit 5 back unchanged
          next_r.sc1_off = hwdata[GATE_SC1_BIT];
          next_r.rsvd    = hwdata[GATE_RSVD_BIT];
        end else if (hit(r.dp_addr, ADDR_SLEEP_CTRL)) begin
          next_r.ds2_sel  = hwdata[CTRL_DS2_BIT];
          next_r.xtal_sel = hwdata[CTRL_XTAL_BIT];
        end else if (hit(r.dp_addr, ADDR_SLEEP_STAT)) begin
          // Write one to clear; new causes below still win
          next_r.wake_cause = r.wake_cause & ~hwdata[STAT_WAKE_LSB +: 3];
        end
        next_r.dp_pend = 1'b0;
      end else if (!r.rd_wait) begin
        // Wait cycle: load read word, bank reads in parallel
        next_r.rd_word = own_word(r, r.dp_addr);
        next_r.rd_mem  = sc1_hit(r.dp_addr);
        next_r.rd_wait = 1'b1;
      end else begin
        // Read completes this cycle
        next_r.dp_pend = 1'b0;
        next_r.rd_wait = 1'b0;
      end
    end

    // Bus address phase, taken only when the bus is ready
    if (hsel && htrans[1] && hready) begin
      next_r.dp_pend  = 1'b1;
      next_r.dp_write = hwrite;
      next_r.dp_addr  = haddr;
      next_r.rd_wait  = 1'b0;
    end

    // Power state machine
    case (r.state)
      DSDPC_RUN: begin
        // Awake; a deep sleep request first enters the hold state
        if (cpu_deep_sleep_req) begin
          next_r.state = DSDPC_PRE;
        end
      end
      DSDPC_PRE: begin
        // Nothing powers off or resets while the system request is set
        if (!sys_req) begin
          if (dbg_req) begin
            next_r.state = DSDPC_EMUL;
          end else begin
            // Both requests clear: a true deep sleep
            next_r.state       = DSDPC_DEEP;
            next_r.ds2_latched = r.ds2_sel;
          end
        end
      end
      DSDPC_DEEP: begin
        // Non-timer, debug and permitted timer wakes
        if (ext_req || timer_ok || dbg_req || sys_req || r.acc_pend) begin
          next_r.state   = DSDPC_WAKE;
          next_r.pwr_cnt = '0;
          if (ext_req) begin
            next_r.wake_cause[WAKE_EXT] = 1'b1;
          end
          if (timer_ok) begin
            next_r.wake_cause[WAKE_TIMER] = 1'b1;
          end
          if (dbg_req || sys_req || r.acc_pend) begin
            next_r.wake_cause[WAKE_DEBUG] = 1'b1;
          end
        end
      end
      DSDPC_WAKE: begin
        // Oscillator back on; core held in reset until power settles
        if (r.pwr_cnt == PWR_CNT_W'(POWERUP_CYCLES - 1)) begin
          next_r.state       = DSDPC_RUN;
          next_r.ds2_latched = 1'b0;
        end else begin
          next_r.pwr_cnt = r.pwr_cnt + PWR_CNT_W'(1);
        end
      end
      DSDPC_EMUL: begin
        // Core stays up, so wake returns straight to running
        if (ext_req || timer_wake_event || sys_req) begin
          next_r.state = DSDPC_RUN;
          if (ext_req) begin
            next_r.wake_cause[WAKE_EXT] = 1'b1;
          end
          if (timer_wake_event) begin
            next_r.wake_cause[WAKE_TIMER] = 1'b1;
          end
          if (sys_req) begin
            next_r.wake_cause[WAKE_DEBUG] = 1'b1;
          end
        end
      end
      default: begin
        // Unused codes recover to running
        next_r.state = DSDPC_RUN;
      end
    endcase
  end

  // State register; rst_n is the power-on reset only, so the request
  // bits live in the debug port and other resets never reach them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      r          <= '0;
      r.state    <= DSDPC_RUN;
      r.sc1_off  <= GATE_RESET[GATE_SC1_BIT];
      r.rsvd     <= GATE_RESET[GATE_RSVD_BIT];
      r.ds2_sel  <= CTRL_RESET[CTRL_DS2_BIT];
      r.xtal_sel <= CTRL_RESET[CTRL_XTAL_BIT];
    end else begin
      r <= next_r;
    end
  end

  // Bank holding the serial controller one registers
  dsdpc_sc1_regs #(
    .WORDS (SC1_WORDS),
    .AW    (SC1_AW)
  ) u_sc1_regs (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .port    (sc1_bus)
  );

  // Power outputs; the core is cut only in true deep sleep
  assign core_power_on  = (r.state != DSDPC_DEEP);
  assign core_reset_n   = ~((r.state == DSDPC_DEEP) | (r.state == DSDPC_WAKE));

  // Sleep 0 resets peripherals; debug parts sit on core_reset_n
  assign periph_reset_n = ~((r.state == DSDPC_EMUL) | (r.state == DSDPC_DEEP) |
                            (r.state == DSDPC_WAKE));

  // Oscillator off only inside deep sleep 2
  assign low_freq_rc_osc_on = ~((r.state == DSDPC_DEEP) & r.ds2_latched);

  // Timer wake path usable
  assign timer_wake_armed = ~((r.state == DSDPC_DEEP) & r.ds2_latched & ~r.xtal_sel);

  // Serial controller clock follows the gate bit
  assign sc1_clk_on = ~r.sc1_off;

  // Debugger held off while the core is down
  assign dp_stall = r.acc_pend & ~ready;
endmodule

// File: testbench/dsdpc_dbg_model.sv
// Behavioural debug tool on the far side of the debug port
`timescale 1ns/1ps
module dsdpc_dbg_model (
  output logic debug_powerup_request,
  output logic system_powerup_request,
  output logic dp_clk,
  output logic dp_access_req,
  input  logic dp_stall
);
  // Link clock rests low between frames
  initial begin
    debug_powerup_request  = 1'b0;
    system_powerup_request = 1'b0;
    dp_clk                 = 1'b0;
    dp_access_req          = 1'b0;
  end
  // Run n link cycles of 125 ns, phase offset from the system clock
  task automatic frame(input int n);
    #3;
    repeat (n) begin
      #62.5 dp_clk = 1'b1;
      #62.5 dp_clk = 1'b0;
    end
  endtask
  // Request bits move only inside a logical transaction
  task automatic set_bits(input logic dbg, input logic sys);
    frame(4);
    debug_powerup_request  = dbg;
    system_powerup_request = sys;
    frame(4);
  endtask
  // Access that waits out the stall; reports whether it was held off
  task automatic access(output logic held);
    int n;
    n             = 0;
    dp_access_req = 1'b1;
    frame(3);
    held = (dp_stall === 1'b1);
    // Bounded so a stuck stall cannot hang the model
    while (dp_stall === 1'b1 && n < 400) begin
      frame(1);
      n++;
    end
    dp_access_req = 1'b0;
    frame(2);
  endtask
endmodule

// File: testbench/dsdpc_top_chk_sva.sv
// Port-level assertions for the deep sleep and debug power controller
`timescale 1ns/1ps
module dsdpc_top_chk (
  input logic sys_clk,
  input logic rst_n,
  input logic hreadyout,
  input logic debug_powerup_request,
  input logic system_powerup_request,
  input logic ext_wake,
  input logic timer_wake_event,
  input logic dp_stall,
  input logic core_power_on,
  input logic core_reset_n,
  input logic periph_reset_n,
  input logic low_freq_rc_osc_on,
  input logic timer_wake_armed
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Oscillator may stop only with the core fully down
  osc_off_a: assert property (
    !low_freq_rc_osc_on |-> !core_power_on && !core_reset_n) else $error("osc off while awake");
  // Timer disarmed only when the oscillator is off
  timer_arm_a: assert property (
    !timer_wake_armed |-> !low_freq_rc_osc_on) else $error("timer disarmed with osc on");
  // Power-up always brings the oscillator back
  osc_restart_a: assert property (
    $rose(core_power_on) |-> low_freq_rc_osc_on) else $error("osc not restarted");
  // Peripherals in reset with core running means core stays powered
  emul_power_a: assert property (
    core_reset_n && !periph_reset_n |-> core_power_on) else $error("emulated sleep lost power");
  // Two sync stages plus one state step bound the wake
  ext_wake_a: assert property (
    !core_power_on && ext_wake |-> ##[1:5] core_power_on) else $error("ext wake missed");
  req_wake_a: assert property (
    !core_power_on && (debug_powerup_request || system_powerup_request) |-> ##[1:5]
    core_power_on) else $error("request wake missed");
  timer_wake_a: assert property (
    !core_power_on && timer_wake_armed && timer_wake_event |=> core_power_on)
    else $error("timer wake missed");
  // Power-down needs both requests clear three samples back (sync delay)
  deep_entry_a: assert property (
    $fell(core_power_on) |-> !$past(system_powerup_request, 3) &&
    !$past(debug_powerup_request, 3)) else $error("deep sleep with request set");
  // Stall only while the core is not yet out of reset
  stall_ready_a: assert property (
    dp_stall |-> !core_reset_n || !$past(core_reset_n)) else $error("stall while ready");
  // Reads carry at most one wait state
  read_wait_a: assert property (
    !hreadyout |=> hreadyout) else $error("wait state too long");
endmodule

bind dsdpc_top dsdpc_top_chk u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .hreadyout(hreadyout),
  .debug_powerup_request(debug_powerup_request),
  .system_powerup_request(system_powerup_request),
  .ext_wake(ext_wake), .timer_wake_event(timer_wake_event), .dp_stall(dp_stall),
  .core_power_on(core_power_on), .core_reset_n(core_reset_n),
  .periph_reset_n(periph_reset_n), .low_freq_rc_osc_on(low_freq_rc_osc_on),
  .timer_wake_armed(timer_wake_armed)
);

// File: testbench/tb_deep_sleep_debug_power_control.sv
// Self-checking bench for the deep sleep and debug power controller
`timescale 1ns/1ps
module tb_deep_sleep_debug_power_control;
  import dsdpc_pkg::*;
  // One register case: address, data written, data expected back
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] wd;
    logic [31:0] exp;
  } dsdpc_row_t;
  logic        sys_clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;  // Whole words only
  logic        hready, hreadyout, hresp, dp_stall, dp_clk, dp_access_req;
  logic        cpu_deep_sleep_req = 1'b0, ext_wake = 1'b0, timer_wake_event = 1'b0;
  logic        debug_powerup_request, system_powerup_request, core_power_on;
  logic        core_reset_n, periph_reset_n, low_freq_rc_osc_on, timer_wake_armed;
  logic        sc1_clk_on, ea, stl;
  int          err_count = 0, checks = 0;
  logic [31:0] cv [3] = '{32'h0, 32'h1, 32'h3};  // Sleep variants: DS1, DS2, DS2 crystal
  dsdpc_row_t  rows [6] = '{
    '{ADDR_CLK_GATE, 32'hffff_ffdd, 32'h0},
    '{ADDR_CLK_GATE, 32'h0000_0002, 32'h0000_0002},
    '{ADDR_CLK_GATE, 32'h0000_0000, 32'h0},
    '{ADDR_SC1_BASE, 32'h1234_5678, 32'h1234_5678},
    '{ADDR_SC1_BASE + 32'h1c, 32'ha5a5_5a5a, 32'ha5a5_5a5a},
    '{32'h4000_4040, 32'hdead_beef, 32'h0}};
  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  // System clock, 8 ns period
  always #4 sys_clk = ~sys_clk;
  dsdpc_top uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .debug_powerup_request(debug_powerup_request),
    .system_powerup_request(system_powerup_request), .dp_clk(dp_clk),
    .dp_access_req(dp_access_req), .dp_stall(dp_stall),
    .cpu_deep_sleep_req(cpu_deep_sleep_req), .ext_wake(ext_wake),
    .timer_wake_event(timer_wake_event), .core_power_on(core_power_on),
    .core_reset_n(core_reset_n), .periph_reset_n(periph_reset_n),
    .low_freq_rc_osc_on(low_freq_rc_osc_on), .timer_wake_armed(timer_wake_armed),
    .sc1_clk_on(sc1_clk_on));
  dsdpc_dbg_model dbg (
    .debug_powerup_request(debug_powerup_request),
    .system_powerup_request(system_powerup_request),
    .dp_clk(dp_clk), .dp_access_req(dp_access_req), .dp_stall(dp_stall));
  // Compare and count; four-state equality so unknowns fail
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Single AHB-Lite transfer; waits on ready, never on a cycle count
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge sys_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  // One-cycle pulse of sleep request or timer event
  task automatic pulse(input logic slp);
    @(posedge sys_clk);
    cpu_deep_sleep_req <= slp;
    timer_wake_event   <= !slp;
    @(posedge sys_clk);
    cpu_deep_sleep_req <= 1'b0;
    timer_wake_event   <= 1'b0;
  endtask
  // Picks one power output for a bounded wait
  function automatic logic pick(input int s);
    case (s)
      0:       return core_power_on;
      1:       return core_reset_n;
      default: return periph_reset_n;
    endcase
  endfunction
  // Bounded wait for a level; 250-cycle power-up fits easily
  task automatic wait_sig(input int s, input logic v);
    int n;
    n = 0;
    @(negedge sys_clk);
    while (pick(s) !== v && n < 600) begin
      @(negedge sys_clk);
      n++;
    end
    chk(32'(pick(s)), 32'(v), "level wait");
  endtask
  // Single exit point of the run
  task automatic end_of_test();
    $display("Summary: %0d checks, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Watchdog, well beyond the expected few thousand cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    err_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    chk(32'({hresp, sc1_clk_on, core_power_on, core_reset_n, periph_reset_n, low_freq_rc_osc_on,
             timer_wake_armed}), 32'h3f, "reset levels");
    ahb(1'b0, ADDR_CLK_GATE, 32'h0, rd);
    chk(rd, GATE_RESET, "gate reset");
    $display("test reset done");
    foreach (rows[i]) begin
      ahb(1'b1, rows[i].a, rows[i].wd, rd);
      ahb(1'b0, rows[i].a, 32'h0, rd);
      chk(rd, rows[i].exp, "register row");
    end
    $display("test registers done");
    // Gated bank drops writes and keeps its last value
    ahb(1'b1, ADDR_SC1_BASE + 32'h4, 32'h0000_00aa, rd);
    ahb(1'b0, ADDR_CLK_GATE, 32'h0, rd);
    ahb(1'b1, ADDR_CLK_GATE, rd | 32'h2, rd);
    repeat (3) @(negedge sys_clk);
    chk(32'(sc1_clk_on), 32'h0, "bank clock off");
    ahb(1'b1, ADDR_SC1_BASE + 32'h4, 32'h0000_0055, rd);
    ahb(1'b0, ADDR_SC1_BASE + 32'h4, 32'h0, rd);
    chk(rd, 32'h0000_00aa, "frozen read");
    ahb(1'b0, ADDR_CLK_GATE, 32'h0, rd);
    ahb(1'b1, ADDR_CLK_GATE, rd & ~32'h2, rd);
    $display("test gating done");
    // Each sleep variant, timer first; the non-timer wake only acts in DS2 without the crystal, where the timer cannot wake the core
    foreach (cv[i]) begin
      ea = !(cv[i][0] && !cv[i][1]);
      ahb(1'b1, ADDR_SLEEP_CTRL, cv[i], rd);
      pulse(1'b1);
      wait_sig(0, 1'b0);
      chk(32'(low_freq_rc_osc_on), 32'(!cv[i][0]), "osc in sleep");
      chk(32'(timer_wake_armed), 32'(ea), "timer armed");
      pulse(1'b0);
      repeat (6) @(negedge sys_clk);
      chk(32'(core_power_on), 32'(ea), "timer wake");
      @(posedge sys_clk);
      ext_wake <= 1'b1;
      wait_sig(0, 1'b1);
      chk(32'(low_freq_rc_osc_on), 32'h1, "osc restarted");
      wait_sig(1, 1'b1);
      @(posedge sys_clk);
      ext_wake <= 1'b0;
    end
    // Status: running, osc on, powered; timer cause from DS1, external from DS2
    repeat (4) @(posedge sys_clk);
    ahb(1'b0, ADDR_SLEEP_STAT, 32'h0, rd);
    chk(rd, 32'h0000_0348, "wake causes");
    ahb(1'b1, ADDR_SLEEP_STAT, 32'h0000_0700, rd);
    ahb(1'b0, ADDR_SLEEP_STAT, 32'h0, rd);
    chk(rd, 32'h0000_0048, "causes cleared");
    $display("test sleep variants done");
    // Debugger connected: only emulated sleep
    dbg.set_bits(1'b1, 1'b0);
    pulse(1'b1);
    wait_sig(2, 1'b0);
    chk(32'({core_power_on, core_reset_n}), 32'h3, "emulated sleep");
    @(posedge sys_clk);
    ext_wake <= 1'b1;
    wait_sig(2, 1'b1);
    @(posedge sys_clk);
    ext_wake <= 1'b0;
    $display("test emulated sleep done");
    // System request holds the pre-sleep state
    dbg.set_bits(1'b0, 1'b1);
    pulse(1'b1);
    repeat (20) @(negedge sys_clk);
    chk(32'({core_power_on, core_reset_n, periph_reset_n}), 32'h7, "pre hold");
    dbg.set_bits(1'b0, 1'b0);
    wait_sig(0, 1'b0);
    dbg.access(stl);
    chk(32'(stl), 32'h1, "access stalled");
    chk(32'(core_reset_n), 32'h1, "ready after stall");
    $display("test pre-sleep and stall done");
    // Setting a request bit wakes deep sleep
    pulse(1'b1);
    wait_sig(0, 1'b0);
    dbg.set_bits(1'b0, 1'b1);
    wait_sig(0, 1'b1);
    dbg.set_bits(1'b0, 1'b0);
    wait_sig(1, 1'b1);
    $display("test request wake done");
    end_of_test();
  end
endmodule
